/* File: dhbc_pkg.sv */
/*
  Shared constants, encodings and carrier types for the disk host bus
  command decoder. Assumes all host lines arrive already converted to
  active-high logic levels by the pad ring.
*/
package dhbc_pkg;

  localparam int BUS_W      = 8;
  localparam int ADDR_W     = 10;
  localparam int CNT_W      = 11;
  localparam int SYNC_W     = 13;

  // Bus state from {data qualifier, direction}
  typedef enum logic [1:0] {
    BUS_STATUS  = 2'b00,
    BUS_COMMAND = 2'b01,
    BUS_RDATA   = 2'b10,
    BUS_WDATA   = 2'b11
  } dhbc_bus_e;

  // Control commands, bit 7 is the most significant bus line
  localparam logic [7:0] CMD_RESET    = 8'h80;
  localparam logic [7:0] CMD_CLR_DS   = 8'h90;
  localparam logic [7:0] CMD_TERM     = 8'ha0;
  localparam logic [3:0] PFX_ADDR_LO  = 4'hc;
  localparam logic [3:0] PFX_ADDR_MID = 4'he;
  localparam logic [5:0] PFX_ADDR_HI  = 6'h3c;

  // Field positions inside the setup bytes
  localparam int CTRL_BIT   = 7;
  localparam int RW_BIT     = 6;
  localparam int SCNT_MSB   = 5;
  localparam int SCNT_LSB   = 4;
  localparam int DISKID_BIT = 3;
  localparam int HEAD_BIT   = 2;
  localparam int TRKHI_MSB  = 1;
  localparam logic [1:0] B2_ZERO = 2'b00;

  // Status byte positions driven by this block
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_DAS_BIT  = 0;

  // Reset values
  localparam logic [ADDR_W-1:0] PTR_RST = 10'h000;
  localparam logic [CNT_W-1:0]  CNT_RST = 11'h000;
  localparam logic [1:0]        SEQ_RST = 2'h0;
  localparam logic              HEAD_UPPER = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RDISK  = 3'b001,
    ST_RHOST  = 3'b010,
    ST_WHOST  = 3'b011,
    ST_FILL   = 3'b100,
    ST_WDISK  = 3'b101,
    ST_RT     = 3'b110
  } dhbc_state_e;

  typedef struct packed {
    logic [8:0] track;
    logic       head;
    logic       disk_id;
    logic [1:0] sector_count_bits;
    logic [5:0] sector;
    logic       write;
  } dhbc_op_s;

  typedef struct packed {
    logic             strobe;
    logic             data_sel;
    logic             transfer_toward_device;
    logic             reset_line;
    logic             parity;
    logic [BUS_W-1:0] data;
  } dhbc_host_s;

  localparam dhbc_op_s OP_RST = '0;

endpackage

/* File: dhbc_sync.sv */
/*
  Two-stage synchroniser for a vector of asynchronous host lines.
  Assumes each line is stable long enough around its strobe to be
  sampled coherently after the second stage.
*/
`timescale 1ns/1ns
module dhbc_sync #(
  parameter int W = 13
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // First stage feeds only the second stage
  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end

endmodule

/* File: dhbc_decoder.sv */
/*
  Host bus front end: bus state decode, command interpreter, setup byte
  sequencing and buffered or real-time transfer control.
  Assumes a disk engine that runs operations on op_start, stops on
  op_stop, reports op_done, and a buffer read back combinationally.
*/
`timescale 1ns/1ns
// Function
// - two select lines choose four bus states
// - idle selects drive status, strobe reads status
// - direction only: strobed byte is a command
// - read data state drives held byte
// - write data state captures strobed bus byte
// - three setup bytes start every operation
// - first byte: zero, seven low track bits
// - second byte: count, disk, head, high track
// - head bit zero upper, one lower
// - sector count chains up to four
// - third byte: read/write and start sector
// - busy ignores setup bytes, runs control
// - reset command resets, clears buffer pointer
// - clear service aborts read, clears busy
// - terminate ends buffered, halts real-time only with external halt
// - three prefixed bytes load buffer address
// - real-time mode bypasses the buffer
// - short write is padded with zeros
// - real-time write: one byte per pulse
// - parity asserted when ones count even
// - strobe release completes the transfer
// - line eight is the least significant
module dhbc_decoder
  import dhbc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire dhbc_pkg::dhbc_host_s     host_in,
  output logic [dhbc_pkg::BUS_W-1:0]    bus_out,
  output logic                          bus_oe,
  output logic                          parity_out,
  output logic                          parity_oe,
  input  wire logic                     realtime_mode,
  input  wire logic                     external_halt,
  input  wire logic [dhbc_pkg::BUS_W-1:0] status_in,
  input  wire logic                     flag_in,
  output logic                          flag,
  output dhbc_pkg::dhbc_op_s            op,
  output logic                          op_start,
  output logic                          op_stop,
  input  wire logic                     op_done,
  output logic [dhbc_pkg::ADDR_W-1:0]   buf_addr,
  input  wire logic [dhbc_pkg::BUS_W-1:0] buf_rd_data,
  output logic                          buf_wr_en,
  output logic [dhbc_pkg::BUS_W-1:0]    buf_wr_data,
  input  wire logic                     rt_xfer_pulse,
  input  wire logic [dhbc_pkg::BUS_W-1:0] rt_rd_data,
  output logic [dhbc_pkg::BUS_W-1:0]    rt_wr_data,
  output logic                          rt_wr_valid,
  output logic                          parity_error,
  output logic                          status_read_pulse,
  output logic                          command_out_pulse,
  output logic                          buffer_read_pulse
);

  // Even number of ones gives an asserted parity line
  function automatic logic even_par(input logic [BUS_W-1:0] b);
    even_par = ~(^b);
  endfunction

  dhbc_host_s  hs;
  dhbc_bus_e   bus_st;
  logic        stb_d_reg, stb_d_next;
  logic        stb_rise, stb_fall;
  logic [BUS_W-1:0] cap_reg, cap_next;
  logic        cap_par_reg, cap_par_next;
  dhbc_bus_e   cap_bus_reg, cap_bus_next;
  dhbc_state_e state_reg, state_next;
  logic [1:0]  seq_reg, seq_next;
  dhbc_op_s    op_reg, op_next;
  dhbc_op_s    pend_reg, pend_next;
  logic [ADDR_W-1:0] ptr_reg, ptr_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [CNT_W-1:0]  limit;
  logic        das_reg, das_next;
  logic        done_reg, done_next;
  logic        rt_reg, rt_next;
  logic [BUS_W-1:0] hold_reg, hold_next;
  logic [BUS_W-1:0] out_reg, out_next;
  logic        oe_reg, oe_next;
  logic        start_reg, start_next, stop_reg, stop_next;
  logic        wr_reg, wr_next;
  logic [BUS_W-1:0] wr_data_reg, wr_data_next;
  logic [BUS_W-1:0] rtw_reg, rtw_next;
  logic        rtv_reg, rtv_next;
  logic        perr_reg, perr_next;
  logic        rss_reg, rss_next, ocs_reg, ocs_next, rds_reg, rds_next;
  logic        busy;

  // Host lines enter the clock domain before any edge is looked at
  dhbc_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (host_in),
    .q    (hs)
  );

  assign bus_st   = dhbc_bus_e'({hs.data_sel, hs.transfer_toward_device});
  assign stb_rise = hs.strobe & ~stb_d_reg;
  assign stb_fall = ~hs.strobe & stb_d_reg;
  assign busy     = (state_reg != ST_IDLE);
  // Chain length is count field plus one sector of 256 bytes
  assign limit    = {({1'b0, op_reg.sector_count_bits} + 3'd1), 8'h00};

  // Outputs from flip-flops; flag also ORs in flag_in, parity is decoded from out_reg
  assign bus_out           = out_reg;
  assign bus_oe            = oe_reg;
  assign parity_out        = even_par(out_reg);
  assign parity_oe         = oe_reg;
  assign flag              = flag_in | das_reg | done_reg;
  assign op                = op_reg;
  assign op_start          = start_reg;
  assign op_stop           = stop_reg;
  assign buf_addr          = ptr_reg;
  assign buf_wr_en         = wr_reg;
  assign buf_wr_data       = wr_data_reg;
  assign rt_wr_data        = rtw_reg;
  assign rt_wr_valid       = rtv_reg;
  assign parity_error      = perr_reg;
  assign status_read_pulse = rss_reg;
  assign command_out_pulse = ocs_reg;
  assign buffer_read_pulse = rds_reg;

  // Control: capture on strobe assertion, act on its release
  always_comb begin
    stb_d_next   = hs.strobe;
    cap_next     = cap_reg;
    cap_par_next = cap_par_reg;
    cap_bus_next = cap_bus_reg;
    state_next   = state_reg;
    seq_next     = seq_reg;
    op_next      = op_reg;
    pend_next    = pend_reg;
    ptr_next     = ptr_reg;
    cnt_next     = cnt_reg;
    das_next     = das_reg;
    done_next    = done_reg;
    rt_next      = rt_reg;
    hold_next    = hold_reg;
    start_next   = 1'b0;
    stop_next    = 1'b0;
    wr_next      = 1'b0;
    wr_data_next = wr_data_reg;
    rtw_next     = rtw_reg;
    rtv_next     = 1'b0;
    perr_next    = 1'b0;
    rss_next     = 1'b0;
    ocs_next     = 1'b0;
    rds_next     = 1'b0;

    // Bus byte, parity and selects are captured on the strobe rising edge
    if (stb_rise) begin
      cap_next     = hs.data;
      cap_par_next = hs.parity;
      cap_bus_next = bus_st;
    end

    // Hold byte frozen while a read strobe is up so it stays valid
    if (rt_reg) begin
      if (rt_xfer_pulse) begin
        hold_next = rt_rd_data;
      end
    end else if (!hs.strobe) begin
      hold_next = buf_rd_data;
    end

    // Real-time write: one byte taken per device transfer pulse
    if (rt_reg && rt_xfer_pulse && bus_st == BUS_WDATA && state_reg == ST_RT) begin
      rtw_next  = hs.data;
      rtv_next  = 1'b1;
      perr_next = (hs.parity != even_par(hs.data));
    end

    if (stb_fall) begin
      case (cap_bus_reg)
        BUS_STATUS: begin
          rss_next  = 1'b1;
          done_next = 1'b0;
        end
        BUS_COMMAND: begin
          ocs_next  = 1'b1;
          perr_next = (cap_par_reg != even_par(cap_reg));
          if (!cap_reg[CTRL_BIT]) begin
            // Setup bytes dropped while an operation runs
            if (!busy) begin
              case (seq_reg)
                2'd0: begin
                  pend_next.track[6:0] = cap_reg[6:0];
                  seq_next = 2'd1;
                end
                2'd1: begin
                  if (cap_reg[7:6] == B2_ZERO) begin
                    pend_next.sector_count_bits = cap_reg[SCNT_MSB:SCNT_LSB];
                    pend_next.disk_id = cap_reg[DISKID_BIT];
                    pend_next.head = cap_reg[HEAD_BIT];
                    pend_next.track[8:7] = cap_reg[TRKHI_MSB:0];
                    seq_next = 2'd2;
                  end else begin
                    seq_next = SEQ_RST;
                  end
                end
                default: begin
                  // Third byte launches the operation
                  op_next = pend_reg;
                  op_next.write = cap_reg[RW_BIT];
                  // Sector field reads with its lowest bit on the third line
                  op_next.sector = {cap_reg[0], cap_reg[1], cap_reg[2],
                                    cap_reg[3], cap_reg[4], cap_reg[5]};
                  seq_next  = SEQ_RST;
                  rt_next   = realtime_mode;
                  cnt_next  = CNT_RST;
                  done_next = 1'b0;
                  if (realtime_mode) begin
                    if (external_halt) begin
                      op_next.sector_count_bits = 2'b00;
                    end
                    state_next = ST_RT;
                    start_next = 1'b1;
                  end else if (cap_reg[RW_BIT]) begin
                    state_next = ST_WHOST;
                    das_next   = 1'b1;
                  end else begin
                    state_next = ST_RDISK;
                    start_next = 1'b1;
                  end
                end
              endcase
            end
          end else if (cap_reg == CMD_RESET) begin
            state_next = ST_IDLE;
            seq_next   = SEQ_RST;
            ptr_next   = PTR_RST;
            das_next   = 1'b0;
            done_next  = 1'b0;
            rt_next    = 1'b0;
            stop_next  = busy;
          end else if (cap_reg == CMD_CLR_DS) begin
            state_next = ST_IDLE;
            das_next   = 1'b0;
            stop_next  = busy;
          end else if (cap_reg == CMD_TERM) begin
            case (state_reg)
              ST_RHOST: begin
                state_next = ST_IDLE;
                das_next   = 1'b0;
                done_next  = 1'b1;
              end
              ST_WHOST: begin
                das_next   = 1'b0;
                state_next = (cnt_reg < limit) ? ST_FILL : ST_WDISK;
                start_next = (cnt_reg >= limit);
              end
              ST_RT: begin
                stop_next = external_halt;
              end
              default: begin
              end
            endcase
          end else if (cap_reg[7:4] == PFX_ADDR_LO) begin
            ptr_next[3:0] = cap_reg[3:0];
          end else if (cap_reg[7:4] == PFX_ADDR_MID) begin
            ptr_next[7:4] = cap_reg[3:0];
          end else if (cap_reg[7:2] == PFX_ADDR_HI) begin
            ptr_next[9:8] = cap_reg[1:0];
          end
        end
        BUS_RDATA: begin
          // Buffered read advances the pointer on strobe release
          if (state_reg == ST_RHOST) begin
            rds_next = 1'b1;
            das_next = 1'b0;
            ptr_next = ptr_reg + 10'h001;
          end
        end
        default: begin
          // Buffered write stores the byte taken at strobe assertion
          if (state_reg == ST_WHOST) begin
            das_next  = 1'b0;
            perr_next = (cap_par_reg != even_par(cap_reg));
            if (cnt_reg < limit) begin
              wr_next      = 1'b1;
              wr_data_next = cap_reg;
              ptr_next     = ptr_reg + 10'h001;
              cnt_next     = cnt_reg + 11'h001;
            end
          end
        end
      endcase
    end else if (!hs.strobe && (state_reg == ST_RHOST || state_reg == ST_WHOST)) begin
      // Request the next byte once the previous strobe has gone
      das_next = 1'b1;
    end

    // Background sequencing of the running operation
    case (state_reg)
      ST_RDISK: begin
        if (op_done) begin
          state_next = ST_RHOST;
          das_next   = 1'b1;
          ptr_next   = PTR_RST;
        end
      end
      ST_FILL: begin
        // Pad the unwritten part of the chain with zeros
        wr_next      = 1'b1;
        wr_data_next = 8'h00;
        ptr_next     = ptr_reg + 10'h001;
        cnt_next     = cnt_reg + 11'h001;
        if (cnt_reg + 11'h001 >= limit) begin
          state_next = ST_WDISK;
          start_next = 1'b1;
        end
      end
      ST_WDISK, ST_RT: begin
        if (op_done) begin
          state_next = ST_IDLE;
          done_next  = 1'b1;
          rt_next    = 1'b0;
        end
      end
      default: begin
      end
    endcase

    // Status byte and read data driven from registers
    case (bus_st)
      BUS_STATUS: begin
        out_next = status_in;
        out_next[STAT_BUSY_BIT] = busy;
        out_next[STAT_DAS_BIT]  = das_reg & ~rt_reg;
        oe_next  = 1'b1;
      end
      BUS_RDATA: begin
        // Real-time byte leaves with its own pulse, not one pulse late
        out_next = (rt_reg && rt_xfer_pulse) ? rt_rd_data : hold_reg;
        oe_next  = rt_reg ? rt_xfer_pulse : (state_reg == ST_RHOST);
      end
      default: begin
        out_next = out_reg;
        oe_next  = 1'b0;
      end
    endcase
  end

  // Host reset line acts like a power-up reset of all front end registers except the synchroniser
  always_ff @(posedge clk) begin
    if (!nrst || hs.reset_line) begin
      stb_d_reg   <= 1'b0;
      cap_reg     <= 8'h00;
      cap_par_reg <= 1'b0;
      cap_bus_reg <= BUS_STATUS;
      state_reg   <= ST_IDLE;
      seq_reg     <= SEQ_RST;
      op_reg      <= OP_RST;
      pend_reg    <= OP_RST;
      ptr_reg     <= PTR_RST;
      cnt_reg     <= CNT_RST;
      das_reg     <= 1'b0;
      done_reg    <= 1'b0;
      rt_reg      <= 1'b0;
      hold_reg    <= 8'h00;
      out_reg     <= 8'h00;
      oe_reg      <= 1'b0;
      start_reg   <= 1'b0;
      stop_reg    <= 1'b0;
      wr_reg      <= 1'b0;
      wr_data_reg <= 8'h00;
      rtw_reg     <= 8'h00;
      rtv_reg     <= 1'b0;
      perr_reg    <= 1'b0;
      rss_reg     <= 1'b0;
      ocs_reg     <= 1'b0;
      rds_reg     <= 1'b0;
    end else begin
      stb_d_reg   <= stb_d_next;
      cap_reg     <= cap_next;
      cap_par_reg <= cap_par_next;
      cap_bus_reg <= cap_bus_next;
      state_reg   <= state_next;
      seq_reg     <= seq_next;
      op_reg      <= op_next;
      pend_reg    <= pend_next;
      ptr_reg     <= ptr_next;
      cnt_reg     <= cnt_next;
      das_reg     <= das_next;
      done_reg    <= done_next;
      rt_reg      <= rt_next;
      hold_reg    <= hold_next;
      out_reg     <= out_next;
      oe_reg      <= oe_next;
      start_reg   <= start_next;
      stop_reg    <= stop_next;
      wr_reg      <= wr_next;
      wr_data_reg <= wr_data_next;
      rtw_reg     <= rtw_next;
      rtv_reg     <= rtv_next;
      perr_reg    <= perr_next;
      rss_reg     <= rss_next;
      ocs_reg     <= ocs_next;
      rds_reg     <= rds_next;
    end
  end

endmodule

/* File: dhbc_decoder_chk_sva.sv */
/*
  Port checker for the host bus command decoder.
  Assumes it is bound to dhbc_decoder and sees only its ports.
*/
`timescale 1ns/1ns
module dhbc_decoder_chk
  import dhbc_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire dhbc_pkg::dhbc_host_s   host_in,
  input wire logic [7:0]             bus_out,
  input wire logic                   bus_oe,
  input wire logic                   parity_out,
  input wire logic                   parity_oe,
  input wire logic                   rt_xfer_pulse,
  input wire logic                   rt_wr_valid,
  input wire logic                   buf_wr_en,
  input wire logic [7:0]             buf_wr_data,
  input wire logic                   status_read_pulse,
  input wire logic                   command_out_pulse,
  input wire logic                   buffer_read_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Pulses come after release, so the raw strobe is already low
  property p_stat;
    status_read_pulse |-> !host_in.strobe && !host_in.data_sel
      && !host_in.transfer_toward_device;
  endproperty
  property p_cmd;
    command_out_pulse |-> !host_in.strobe && !host_in.data_sel
      && host_in.transfer_toward_device;
  endproperty
  property p_rds;
    buffer_read_pulse |-> host_in.data_sel && !host_in.transfer_toward_device;
  endproperty
  // Sync plus output register lag stays well under six cycles
  property p_dir;
    host_in.transfer_toward_device [*6] |=> !bus_oe;
  endproperty
  property p_par;
    bus_oe |-> parity_out == ~^bus_out;
  endproperty
  // Status selects held past sync depth leave byte and parity driven
  property p_par_oe;
    (!host_in.data_sel && !host_in.transfer_toward_device) [*4] |-> bus_oe && parity_oe;
  endproperty
  property p_rt;
    rt_wr_valid |-> $past(rt_xfer_pulse);
  endproperty
  // Zero fill is excluded since it runs with command selects
  property p_wr;
    buf_wr_en && buf_wr_data != 8'h00 |-> host_in.data_sel
      && host_in.transfer_toward_device;
  endproperty

  a_stat:   assert property (p_stat) else $error("status pulse outside status state");
  a_cmd:    assert property (p_cmd) else $error("command pulse outside command state");
  a_rds:    assert property (p_rds) else $error("read pulse outside read data state");
  a_dir:    assert property (p_dir) else $error("device drives bus toward device");
  a_par:    assert property (p_par) else $error("parity out wrong");
  a_par_oe: assert property (p_par_oe) else $error("status byte not driven");
  a_rt:     assert property (p_rt) else $error("realtime write without pulse");
  a_wr:     assert property (p_wr) else $error("buffer write outside write state");

  c_cmd: cover property (command_out_pulse);
  c_rds: cover property (buffer_read_pulse);
  c_rt:  cover property (rt_wr_valid);
endmodule

/* File: dhbc_host_model.sv */
/*
  Host side model: drives selects, byte, parity and strobe.
  Assumes the bench merges its byte with the device drive on the bus.
*/
`timescale 1ns/1ns
module dhbc_host_model
  import dhbc_pkg::*;
(
  input  wire logic            clk,
  output dhbc_pkg::dhbc_host_s h,
  output logic                 drv
);
  // Idle: nothing selected, bus released
  initial begin
    h   = '0;
    drv = 1'b0;
  end

  // Selects and byte; the bus is driven only toward the device
  task automatic put(input logic [1:0] sel, input logic [7:0] d, input logic bad);
    @(negedge clk);
    h.data_sel               = sel[1];
    h.transfer_toward_device = sel[0];
    drv                      = sel[0];
    h.data                   = d;
    h.parity                 = ~^d ^ bad;
  endtask

  // Strobe held past sync depth; selects kept stable after release
  task automatic xfer(input logic [1:0] sel, input logic [7:0] d, input logic bad);
    put(sel, d, bad);
    repeat (2) @(negedge clk);
    h.strobe = 1'b1;
    repeat (5) @(negedge clk);
    h.strobe = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule

/* File: dhbc_decoder_tb_top.sv */
/*
  Testbench for the host bus command decoder.
  Assumes the host model file and the checker are compiled first.
*/
`timescale 1ns/1ns
module dhbc_decoder_tb_top;
  import dhbc_pkg::*;
  logic       clk, nrst, realtime_mode, external_halt, flag_in, op_done, rt_xfer_pulse;
  logic       bus_oe, parity_out, parity_oe, flag, op_start, op_stop, buf_wr_en;
  logic       rt_wr_valid, parity_error, status_read_pulse, command_out_pulse;
  logic       buffer_read_pulse, drv;
  logic [7:0] bus_out, status_in, buf_wr_data, rt_wr_data, last_wd, last_rt, rt_rd;
  logic [9:0] buf_addr;
  logic [8:0] pv;
  dhbc_op_s   op;
  dhbc_host_s h, hin;
  int         cnt[9];
  int         cyc, error_cnt, n_compared;

  // Released lines fall to the inactive level of the pull-up
  assign hin = '{strobe: h.strobe, data_sel: h.data_sel,
    transfer_toward_device: h.transfer_toward_device, reset_line: h.reset_line,
    parity: drv ? h.parity : (bus_oe & parity_out),
    data: drv ? h.data : (bus_oe ? bus_out : 8'h00)};
  assign pv = {parity_error, rt_wr_valid, op_stop, op_start,
    buf_wr_en && buf_wr_data == 8'h00, buf_wr_en, buffer_read_pulse,
    command_out_pulse, status_read_pulse};

  dhbc_host_model host (.clk(clk), .h(h), .drv(drv));
  dhbc_decoder dut (.clk(clk), .nrst(nrst), .host_in(hin), .bus_out(bus_out),
    .bus_oe(bus_oe), .parity_out(parity_out), .parity_oe(parity_oe),
    .realtime_mode(realtime_mode), .external_halt(external_halt),
    .status_in(status_in), .flag_in(flag_in), .flag(flag), .op(op),
    .op_start(op_start), .op_stop(op_stop), .op_done(op_done), .buf_addr(buf_addr),
    .buf_rd_data(buf_addr[7:0] ^ 8'h5a), .buf_wr_en(buf_wr_en),
    .buf_wr_data(buf_wr_data), .rt_xfer_pulse(rt_xfer_pulse),
    .rt_rd_data(rt_rd), .rt_wr_data(rt_wr_data), .rt_wr_valid(rt_wr_valid),
    .parity_error(parity_error), .status_read_pulse(status_read_pulse),
    .command_out_pulse(command_out_pulse), .buffer_read_pulse(buffer_read_pulse));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Event counters and last written bytes; timeout cuts a hang
  always @(posedge clk) begin
    for (int i = 0; i < 9; i++) cnt[i] += pv[i];
    if (buf_wr_en && buf_wr_data != 8'h00) last_wd = buf_wr_data;
    if (rt_wr_valid) last_rt = rt_wr_data;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ckc(input int i, input int exp);
    ck($sformatf("event count %0d", i), cnt[i], exp);
  endtask

  task automatic clr();
    @(negedge clk);
    cnt = '{default: 0};
  endtask

  task automatic setup(input logic [7:0] b1, b2, b3);
    host.xfer(2'b01, b1, 1'b0);
    host.xfer(2'b01, b2, 1'b0);
    host.xfer(2'b01, b3, 1'b0);
  endtask

  // Select status state and look at busy and data service bits
  task automatic stat(input logic b, input logic d);
    host.put(2'b00, 8'h00, 1'b0);
    repeat (6) @(negedge clk);
    ck("busy bit", bus_out[2], b);
    ck("service bit", bus_out[0], d);
  endtask

  task automatic done_pulse();
    @(negedge clk);
    op_done = 1'b1;
    @(negedge clk);
    op_done = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Selects settle past the sync, then one device transfer pulse
  task automatic rt_pulse(input logic [1:0] sel, input logic [7:0] d);
    host.put(sel, d, 1'b0);
    repeat (6) @(negedge clk);
    rt_xfer_pulse = 1'b1;
    @(negedge clk);
    rt_xfer_pulse = 1'b0;
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    {realtime_mode, external_halt, flag_in, op_done, rt_xfer_pulse} = 5'h00;
    status_in = 8'ha2;
    rt_rd = 8'h96;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    stat(1'b0, 1'b0);
    ck("status byte", bus_out & 8'hfa, 8'ha2);
    ck("status drive", bus_oe, 1'b1);
    clr();
    host.xfer(2'b00, 8'h00, 1'b0);
    ckc(0, 1);
    setup(8'h55, 8'h1e, 8'h0a);
    ckc(1, 3);
    ckc(5, 1);
    ck("op", {12'h0, op}, {12'h0, 9'h155, 1'b1, 1'b1, 2'b01, 6'h14, 1'b0});
    setup(8'h01, 8'h00, 8'h4a);
    ckc(5, 1);
    ck("track kept", op.track, 9'h155);
    done_pulse();
    stat(1'b1, 1'b1);
    ck("flag", flag, 1'b1);
    host.put(2'b10, 8'h00, 1'b0);
    repeat (6) @(negedge clk);
    ck("read byte", {bus_oe, bus_out}, 9'h15a);
    host.xfer(2'b10, 8'h00, 1'b0);
    ckc(2, 1);
    ck("pointer", buf_addr, 10'h001);
    setup(8'hc3, 8'he5, 8'hf2);
    ck("pointer load", buf_addr, 10'h253);
    host.xfer(2'b01, CMD_TERM, 1'b0);
    stat(1'b0, 1'b0);
    ck("done flag", flag, 1'b1);
    host.xfer(2'b00, 8'h00, 1'b0);
    ck("flag cleared", flag, 1'b0);
    host.xfer(2'b01, CMD_RESET, 1'b0);
    ck("pointer reset", buf_addr, 10'h000);
    clr();
    setup(8'h00, 8'h00, 8'h40);
    host.xfer(2'b11, 8'ha5, 1'b0);
    ckc(3, 1);
    ck("write byte", last_wd, 8'ha5);
    host.xfer(2'b01, CMD_TERM, 1'b0);
    for (int i = 0; i < 600 && cnt[5] == 0; i++) @(negedge clk);
    ckc(4, 255);
    ckc(5, 1);
    done_pulse();
    clr();
    setup(8'h00, 8'h00, 8'h00);
    host.xfer(2'b01, CMD_CLR_DS, 1'b0);
    stat(1'b0, 1'b0);
    ckc(6, 1);
    host.xfer(2'b01, 8'hc0, 1'b1);
    ckc(8, 1);
    clr();
    realtime_mode = 1'b1;
    external_halt = 1'b1;
    setup(8'h00, 8'h30, 8'h40);
    ck("halt count", op.sector_count_bits, 2'b00);
    rt_pulse(2'b11, 8'h3c);
    repeat (3) @(negedge clk);
    ckc(7, 1);
    ck("realtime byte", last_rt, 8'h3c);
    rt_pulse(2'b10, 8'h00);
    ck("realtime read", {bus_oe, bus_out}, 9'h196);
    host.xfer(2'b01, CMD_TERM, 1'b0);
    ckc(6, 1);
    done_pulse();
    print_verdict();
  end
endmodule

bind dhbc_decoder dhbc_decoder_chk u_chk (.clk, .nrst, .host_in, .bus_out, .bus_oe,
  .parity_out, .parity_oe, .rt_xfer_pulse, .rt_wr_valid, .buf_wr_en, .buf_wr_data,
  .status_read_pulse, .command_out_pulse, .buffer_read_pulse);
